/* rtl/imc_pkg.sv */
package imc_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS   = 10;
	localparam int FRAME_NS        = 125000;
	localparam int SLOTS_PER_FRAME = 256;
	localparam int FILL_FRAMES     = 2;
	// Host waits one frame more than the fill needs: the first pulse may be partial
	localparam int GUARD_PULSES    = FILL_FRAMES + 1;
	localparam int EVAL_LOW_PULSES = 2;
	// ****************************************
	// Parallel port map
	// ****************************************
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_IMS        = 8'h01;
	localparam int          CTRL_PERMIT_BIT = 5;
	localparam int          IMS_VALUE_LSB   = 5;
	localparam int          IMS_VALUE_W     = 5;
	localparam int          IMS_START_BIT   = 4;
	localparam int          IMS_STANDBY_BIT = 3;
	localparam int          IMS_EVAL_BIT    = 2;
	localparam logic [15:0] IMS_USED_MASK   = 16'h03fc;
	localparam logic [15:0] IMS_START_MASK  = 16'h0010;
	localparam logic [15:0] REG_RESET       = 16'h0000;
	localparam int          CM_WORDS        = 512;
	localparam int          CM_ADDR_W       = 9;
	localparam int          CM_CLEAR_W      = 11;
	localparam int          SERIAL_LINES    = 16;
	// ****************************************
	// Host AXI4-Lite map
	// ****************************************
	localparam logic [7:0]  OFS_CMD         = 8'h00;
	localparam logic [7:0]  OFS_STATUS      = 8'h04;
	localparam logic [7:0]  OFS_IRQ_STAT    = 8'h08;
	localparam logic [7:0]  OFS_IRQ_CLR     = 8'h0c;
	localparam logic [7:0]  OFS_IRQ_EN      = 8'h10;
	localparam int          CMD_ADDR_LSB    = 16;
	localparam int          CMD_WE_BIT      = 31;
	localparam int          ST_BUSY_BIT     = 16;
	localparam int          IRQ_DONE        = 0;
	localparam int          IRQ_REFUSED     = 1;
	localparam int          IRQ_W           = 2;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

/* rtl/imc_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface imc_if;
	logic        port_req;    // One-cycle access strobe
	logic        port_we;     // Write when high
	logic [7:0]  port_addr;   // Register address
	logic [15:0] port_wdata;  // Write data
	logic        port_ack;    // One-cycle answer
	logic [15:0] port_rdata;  // Read data, valid with ack
	logic        frame_pulse; // One cycle per frame
	modport device (
		input  port_req, port_we, port_addr, port_wdata,
		output port_ack, port_rdata, frame_pulse
	);
	modport host (
		output port_req, port_we, port_addr, port_wdata,
		input  port_ack, port_rdata, frame_pulse
	);
endinterface
`default_nettype wire

/* rtl/imc_device.sv */
// Functional notes
// - Host writes zero to unused bits (host masks only the mode register; control words pass unmasked)
// - Five-bit fill value at bits 9-5
// - Fill value goes to word bits 15-11
// - Word bits 10-0 cleared during fill
// - Fill starts only on start rising edge
// - Host sets start and value together
// - Fill completes within two frames
// - Start bit self-clears when fill done
// - Host may abort by writing zero
// - Host keeps other bits two frames
// - Pin low: standby bit gates outputs
// - Pin high: outputs always driven
// - Evaluation starts on start rising edge
// - Evaluation stops on done rising edge
// - Eval start low one frame first
`timescale 1ns/100ps
`default_nettype none
module imc_device
	import imc_pkg::*;
#(
	parameter int FRAME_CYCLES = FRAME_NS / CLK_PERIOD_NS
) (
	input  wire logic                    aclk,             // Clock
	input  wire logic                    aresetn,          // Sync reset, low
	imc_if.device                        port,             // Parallel port
	input  wire logic                    output_drive_pin, // Async pin
	input  wire logic                    frame_eval_done,  // Done flag
	output logic [SERIAL_LINES-1:0]      serial_out_en,    // Line enables
	output logic                         eval_running,     // Evaluation on
	output logic                         cm_wr_en,         // Memory strobe
	output logic [CM_ADDR_W-1:0]         cm_addr,          // Memory address
	output logic [15:0]                  cm_wdata          // Memory word
);
	localparam int FC_W        = $clog2(FRAME_CYCLES);
	localparam int SLOT_RAW    = FRAME_CYCLES / SLOTS_PER_FRAME;
	localparam int SLOT_CYCLES = (SLOT_RAW < 1) ? 1 : SLOT_RAW;
	localparam int SC_W        = (SLOT_CYCLES < 2) ? 1 : $clog2(SLOT_CYCLES);

	logic [FC_W-1:0]        frame_cnt_ff;
	logic                   frame_pulse_ff;
	logic [SC_W-1:0]        slot_cnt_ff;
	logic                   slot_tick_ff;
	logic                   permit_ff;
	logic [IMS_VALUE_W-1:0] value_ff;
	logic                   start_ff;
	logic                   standby_ff;
	logic                   eval_start_ff;
	logic                   fill_active_ff;
	logic [CM_ADDR_W-1:0]   fill_addr_ff;
	logic                   drive_meta_ff;
	logic                   drive_sync_ff;
	logic                   done_q_ff;
	logic                   eval_running_ff;
	logic [SERIAL_LINES-1:0] serial_out_en_ff;
	logic                   cm_wr_en_ff;
	logic [CM_ADDR_W-1:0]   cm_addr_ff;
	logic [15:0]            cm_wdata_ff;
	logic                   ack_ff;
	logic [15:0]            rdata_ff;

	logic wr;
	logic ims_wr;
	logic ctrl_wr;
	logic fill_go;
	logic fill_abort;
	logic fill_last;
	logic eval_go;
	logic done_rise;

	// ****************************************
	// Register write decode
	// ****************************************
	assign wr      = port.port_req & port.port_we;
	assign ims_wr  = wr & (port.port_addr == ADDR_IMS);
	assign ctrl_wr = wr & (port.port_addr == ADDR_CTRL);
	assign fill_go = ims_wr & port.port_wdata[IMS_START_BIT] & ~start_ff & permit_ff;
	// Zero on start or on permit while busy ends the fill early
	assign fill_abort = fill_active_ff
		& ((ims_wr & ~port.port_wdata[IMS_START_BIT])
		| (ctrl_wr & ~port.port_wdata[CTRL_PERMIT_BIT]));
	assign fill_last = fill_active_ff & slot_tick_ff
		& (fill_addr_ff == CM_ADDR_W'(CM_WORDS - 1));
	assign eval_go   = ims_wr & port.port_wdata[IMS_EVAL_BIT] & ~eval_start_ff;
	assign done_rise = frame_eval_done & ~done_q_ff;

	// ****************************************
	// Frame and channel slot timing
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_cnt_ff   <= '0;
			frame_pulse_ff <= 1'b0;
		end else if (frame_cnt_ff == FC_W'(FRAME_CYCLES - 1)) begin
			frame_cnt_ff   <= '0;
			frame_pulse_ff <= 1'b1;
		end else begin
			frame_cnt_ff   <= frame_cnt_ff + 1'b1;
			frame_pulse_ff <= 1'b0;
		end
	end

	// Slot length rounds down so 512 slots never outlast two frames
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slot_cnt_ff  <= '0;
			slot_tick_ff <= 1'b0;
		end else if (slot_cnt_ff == SC_W'(SLOT_CYCLES - 1)) begin
			slot_cnt_ff  <= '0;
			slot_tick_ff <= 1'b1;
		end else begin
			slot_cnt_ff  <= slot_cnt_ff + 1'b1;
			slot_tick_ff <= 1'b0;
		end
	end

	// ****************************************
	// Control register permit bit
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			permit_ff <= 1'b0;
		end else if (ctrl_wr) begin
			permit_ff <= port.port_wdata[CTRL_PERMIT_BIT];
		end
	end

	// ****************************************
	// Mode register fields
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value_ff      <= '0;
			standby_ff    <= 1'b0;
			eval_start_ff <= 1'b0;
		end else if (ims_wr) begin
			value_ff      <= port.port_wdata[IMS_VALUE_LSB +: IMS_VALUE_W];
			standby_ff    <= port.port_wdata[IMS_STANDBY_BIT];
			eval_start_ff <= port.port_wdata[IMS_EVAL_BIT];
		end
	end

	// A start without permit is not kept, so it cannot stick at one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_ff <= 1'b0;
		end else if (ims_wr) begin
			start_ff <= port.port_wdata[IMS_START_BIT] & permit_ff;
		end else if (fill_last | fill_abort) begin
			start_ff <= 1'b0;
		end
	end

	// ****************************************
	// Block fill engine
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fill_active_ff <= 1'b0;
			fill_addr_ff   <= '0;
		end else if (fill_go) begin
			fill_active_ff <= 1'b1;
			fill_addr_ff   <= '0;
		end else if (fill_abort | fill_last) begin
			fill_active_ff <= 1'b0;
		end else if (fill_active_ff & slot_tick_ff) begin
			fill_addr_ff   <= fill_addr_ff + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cm_wr_en_ff <= 1'b0;
			cm_addr_ff  <= '0;
			cm_wdata_ff <= REG_RESET;
		end else begin
			cm_wr_en_ff <= fill_active_ff & slot_tick_ff & ~fill_abort;
			cm_addr_ff  <= fill_addr_ff;
			cm_wdata_ff <= {value_ff, {CM_CLEAR_W{1'b0}}};
		end
	end

	// ****************************************
	// Output standby
	// ****************************************
	// Pin comes from outside; two flops before use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drive_meta_ff <= 1'b0;
			drive_sync_ff <= 1'b0;
		end else begin
			drive_meta_ff <= output_drive_pin;
			drive_sync_ff <= drive_meta_ff;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_out_en_ff <= '0;
		end else begin
			serial_out_en_ff <= {SERIAL_LINES{drive_sync_ff | standby_ff}};
		end
	end

	// ****************************************
	// Frame evaluation
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_q_ff       <= 1'b0;
			eval_running_ff <= 1'b0;
		end else begin
			done_q_ff <= frame_eval_done;
			if (eval_go) begin
				eval_running_ff <= 1'b1;
			end else if (done_rise) begin
				eval_running_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// Read back and answer
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ack_ff   <= 1'b0;
			rdata_ff <= REG_RESET;
		end else begin
			ack_ff   <= port.port_req;
			rdata_ff <= REG_RESET;
			if (port.port_req & ~port.port_we) begin
				if (port.port_addr == ADDR_IMS) begin
					rdata_ff[IMS_VALUE_LSB +: IMS_VALUE_W] <= value_ff;
					rdata_ff[IMS_START_BIT]   <= start_ff;
					rdata_ff[IMS_STANDBY_BIT] <= standby_ff;
					rdata_ff[IMS_EVAL_BIT]    <= eval_start_ff;
				end else if (port.port_addr == ADDR_CTRL) begin
					rdata_ff[CTRL_PERMIT_BIT] <= permit_ff;
				end
			end
		end
	end

	assign port.port_ack    = ack_ff;
	assign port.port_rdata  = rdata_ff;
	assign port.frame_pulse = frame_pulse_ff;
	assign serial_out_en    = serial_out_en_ff;
	assign eval_running     = eval_running_ff;
	assign cm_wr_en         = cm_wr_en_ff;
	assign cm_addr          = cm_addr_ff;
	assign cm_wdata         = cm_wdata_ff;
endmodule
`default_nettype wire

/* rtl/imc_host.sv */
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module imc_host
	import imc_pkg::*;
(
	input  wire logic        aclk,          // Clock
	input  wire logic        aresetn,       // Sync reset, low
	input  wire logic [7:0]  s_axi_awaddr,  // Write address
	input  wire logic        s_axi_awvalid, // Write address valid
	output logic             s_axi_awready, // Write address ready
	input  wire logic [31:0] s_axi_wdata,   // Write data
	input  wire logic [3:0]  s_axi_wstrb,   // Byte strobes
	input  wire logic        s_axi_wvalid,  // Write data valid
	output logic             s_axi_wready,  // Write data ready
	output logic [1:0]       s_axi_bresp,   // Write response
	output logic             s_axi_bvalid,  // Response valid
	input  wire logic        s_axi_bready,  // Response ready
	input  wire logic [7:0]  s_axi_araddr,  // Read address
	input  wire logic        s_axi_arvalid, // Read address valid
	output logic             s_axi_arready, // Read address ready
	output logic [31:0]      s_axi_rdata,   // Read data
	output logic [1:0]       s_axi_rresp,   // Read response
	output logic             s_axi_rvalid,  // Read valid
	input  wire logic        s_axi_rready,  // Read ready
	output logic             irq,           // Level interrupt
	imc_if.host              port           // Parallel port
);
	logic             awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic             aw_held_ff, w_held_ff;
	logic [7:0]       aw_addr_ff;
	logic [31:0]      w_data_ff;
	logic [3:0]       w_strb_ff;
	logic [1:0]       bresp_ff, rresp_ff;
	logic [31:0]      rdata_ff;
	logic             req_ff, we_ff, busy_ff, irq_ff;
	logic [7:0]       addr_ff;
	logic [15:0]      wdat_ff, last_rdata_ff, last_ims_ff;
	logic [1:0]       guard_ff, low_cnt_ff;
	logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff;

	logic             do_write, cmd_wr, hit;
	logic [31:0]      cmd;
	logic [15:0]      new_word;
	logic             to_ims, refuse;
	logic [IRQ_W-1:0] events, clr;

	// ****************************************
	// Write decode
	// ****************************************
	assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign hit = (aw_addr_ff == OFS_CMD) | (aw_addr_ff == OFS_IRQ_CLR)
		| (aw_addr_ff == OFS_IRQ_EN);
	assign cmd_wr   = do_write & (aw_addr_ff == OFS_CMD);
	assign cmd      = w_data_ff;
	assign to_ims   = cmd[CMD_WE_BIT] & (cmd[CMD_ADDR_LSB +: 8] == ADDR_IMS);
	assign new_word = to_ims ? (cmd[15:0] & IMS_USED_MASK) : cmd[15:0];
	// Only start and its abort may change while a fill is under way
	assign refuse = busy_ff | (to_ims & (((guard_ff != 2'h0)
		& ((new_word & ~IMS_START_MASK) != (last_ims_ff & ~IMS_START_MASK)))
		| (new_word[IMS_EVAL_BIT] & ~last_ims_ff[IMS_EVAL_BIT]
		& (low_cnt_ff < 2'(EVAL_LOW_PULSES)))));
	assign clr    = (do_write & (aw_addr_ff == OFS_IRQ_CLR) & w_strb_ff[0])
		? w_data_ff[IRQ_W-1:0] : '0;
	assign events = {cmd_wr & refuse, port.port_ack};

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			awready_ff <= 1'b1;
			aw_addr_ff <= '0;
		end else if (s_axi_awvalid & awready_ff) begin
			aw_held_ff <= 1'b1;
			awready_ff <= 1'b0;
			aw_addr_ff <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff <= 1'b0;
			wready_ff <= 1'b1;
			w_data_ff <= '0;
			w_strb_ff <= '0;
		end else if (s_axi_wvalid & wready_ff) begin
			w_held_ff <= 1'b1;
			wready_ff <= 1'b0;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_ff <= 1'b0;
			wready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
		end else if (s_axi_arvalid & arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= '0;
			rresp_ff   <= RESP_OKAY;
			case (s_axi_araddr)
				OFS_STATUS:   rdata_ff <= {15'h0, busy_ff, last_rdata_ff};
				OFS_IRQ_STAT: rdata_ff <= {30'h0, irq_stat_ff};
				OFS_IRQ_EN:   rdata_ff <= {30'h0, irq_en_ff};
				OFS_CMD, OFS_IRQ_CLR: rdata_ff <= '0;
				default:      rresp_ff <= RESP_SLVERR;
			endcase
		end else if (rvalid_ff & s_axi_rready) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// ****************************************
	// Parallel port master
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_ff  <= 1'b0;
			we_ff   <= 1'b0;
			addr_ff <= '0;
			wdat_ff <= '0;
			busy_ff <= 1'b0;
		end else begin
			req_ff <= 1'b0;
			if (cmd_wr & ~refuse) begin
				req_ff  <= 1'b1;
				we_ff   <= cmd[CMD_WE_BIT];
				addr_ff <= cmd[CMD_ADDR_LSB +: 8];
				wdat_ff <= new_word;
				busy_ff <= 1'b1;
			end else if (port.port_ack) begin
				busy_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_rdata_ff <= '0;
		end else if (port.port_ack) begin
			last_rdata_ff <= port.port_rdata;
		end
	end

	// ****************************************
	// Frame guards on the mode register
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_ims_ff <= REG_RESET;
			guard_ff    <= '0;
			low_cnt_ff  <= 2'(EVAL_LOW_PULSES);
		end else if (cmd_wr & ~refuse & to_ims) begin
			last_ims_ff <= new_word;
			// Re-armed on every start write: the host cannot see whether permit let it through
			if (new_word[IMS_START_BIT]) begin
				guard_ff <= 2'(GUARD_PULSES);
			end
			if (new_word[IMS_EVAL_BIT]) begin
				low_cnt_ff <= '0;
			end
		end else if (port.frame_pulse) begin
			if (guard_ff != 2'h0) begin
				guard_ff <= guard_ff - 1'b1;
			end
			if (~last_ims_ff[IMS_EVAL_BIT] & (low_cnt_ff < 2'(EVAL_LOW_PULSES))) begin
				low_cnt_ff <= low_cnt_ff + 1'b1;
			end
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= '0;
			irq_en_ff   <= '0;
			irq_ff      <= 1'b0;
		end else begin
			// A new event wins over a clear in the same cycle
			irq_stat_ff <= (irq_stat_ff & ~clr) | events;
			irq_ff      <= |(irq_stat_ff & irq_en_ff);
			if (do_write & (aw_addr_ff == OFS_IRQ_EN) & w_strb_ff[0]) begin
				irq_en_ff <= w_data_ff[IRQ_W-1:0];
			end
		end
	end

	assign s_axi_awready   = awready_ff;
	assign s_axi_wready    = wready_ff;
	assign s_axi_bvalid    = bvalid_ff;
	assign s_axi_bresp     = bresp_ff;
	assign s_axi_arready   = arready_ff;
	assign s_axi_rvalid    = rvalid_ff;
	assign s_axi_rdata     = rdata_ff;
	assign s_axi_rresp     = rresp_ff;
	assign irq             = irq_ff;
	assign port.port_req   = req_ff;
	assign port.port_we    = we_ff;
	assign port.port_addr  = addr_ff;
	assign port.port_wdata = wdat_ff;
endmodule
`default_nettype wire

/* sim/imc_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module imc_chk
	import imc_pkg::*;
#(
	parameter int FRAME_CYCLES = 512
) (
	input  wire logic        aclk,       // Clock
	input  wire logic        aresetn,    // Sync reset, low
	input  wire logic        port_req,   // Access strobe
	input  wire logic        port_we,    // Write when high
	input  wire logic [7:0]  port_addr,  // Register address
	input  wire logic [15:0] port_wdata, // Write data
	input  wire logic        port_ack,   // Answer strobe
	input  wire logic [15:0] port_rdata, // Read data
	input  wire logic        frame_pulse // Frame tick
);
	logic [15:0] cnt_ff;
	logic        seen_ff;
	logic        ev_ff;
	logic [1:0]  low_ff;
	wire logic   ims_wr = port_req && port_we && port_addr == ADDR_IMS;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff  <= 16'h0000;
			seen_ff <= 1'b0;
		end else if (frame_pulse) begin
			cnt_ff  <= 16'h0000;
			seen_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	// Counts frames with the evaluation bit low; saturates, so reset counts as long low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_ff  <= 1'b0;
			low_ff <= 2'h3;
		end else begin
			if (ims_wr)
				ev_ff <= port_wdata[IMS_EVAL_BIT];
			if (ims_wr && !port_wdata[IMS_EVAL_BIT] && ev_ff)
				low_ff <= 2'h0;
			else if (frame_pulse && !ev_ff && low_ff != 2'h3)
				low_ff <= low_ff + 2'h1;
		end
	end

	ack_follows_req_a: assert property (port_req |=> port_ack)
		else $error("no answer one cycle after request");
	ack_has_cause_a: assert property (port_ack |-> $past(port_req))
		else $error("answer without request");
	req_spacing_a: assert property (port_req |=> !port_req)
		else $error("requests closer than two cycles");
	wr_rdata_zero_a: assert property (port_ack && $past(port_we) |-> port_rdata == 16'h0000)
		else $error("read data not zero on write answer");
	unused_zero_a: assert property (ims_wr |-> (port_wdata & ~IMS_USED_MASK) == 16'h0000)
		else $error("unused mode bits written nonzero");
	frame_period_a: assert property (frame_pulse && seen_ff |-> cnt_ff == FRAME_CYCLES - 1)
		else $error("frame tick period wrong");
	frame_bound_a: assert property (seen_ff |-> cnt_ff < FRAME_CYCLES)
		else $error("frame tick missing");
	eval_gap_a: assert property (ims_wr && port_wdata[IMS_EVAL_BIT] && !ev_ff |-> low_ff != 2'h0)
		else $error("evaluation restarted without a low frame");
endmodule
`default_nettype wire

/* sim/test_interface_mode_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_interface_mode_control import imc_pkg::*;;
	localparam int FC = 512;
	logic        aclk = 1'b0, aresetn = 1'b0, pin = 1'b0, done = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awready, wready, bvalid, arready, rvalid, irq, evr, cwe;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] sen, cwd;
	logic [8:0]  caddr;
	logic [8:0]  xaddr = 9'h000;
	logic [4:0]  val = 5'h00;
	int          fail_count = 0, checks = 0, ncm = 0, cyc = 0;

	imc_if u_imc_if ();
	imc_device #(.FRAME_CYCLES(FC)) u_imc_device (.aclk(aclk), .aresetn(aresetn),
		.port(u_imc_if), .output_drive_pin(pin), .frame_eval_done(done),
		.serial_out_en(sen), .eval_running(evr), .cm_wr_en(cwe), .cm_addr(caddr),
		.cm_wdata(cwd));
	imc_host u_imc_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq), .port(u_imc_if));
	imc_chk #(.FRAME_CYCLES(FC)) u_imc_chk (.aclk(aclk), .aresetn(aresetn),
		.port_req(u_imc_if.port_req), .port_we(u_imc_if.port_we),
		.port_addr(u_imc_if.port_addr), .port_wdata(u_imc_if.port_wdata),
		.port_ack(u_imc_if.port_ack), .port_rdata(u_imc_if.port_rdata),
		.frame_pulse(u_imc_if.frame_pulse));

	initial begin
		forever #5 aclk = ~aclk;
	end

	// ****************************************
	// Helpers
	// ****************************************
	function logic [15:0] cm_word(input logic [4:0] v);
		return {v, 11'h000};
	endfunction
	function logic [15:0] drive(input logic p, input logic b);
		return {16{p | b}};
	endfunction
	function logic [15:0] interface_mode_reg(input logic [4:0] v, input logic st, input logic sb,
		input logic ev);
		return {6'h00, v, st, sb, ev, 2'h0};
	endfunction

	task check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %0t: got %h want %h", $time, s, e);
		end
	endtask
	task results;
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task tmo(input int n);
		if (n >= 200) begin
			check(32'h0, 32'h1);
			results;
		end
	endtask

	// Address and data offered together, each dropped once taken
	task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		tmo(n);
	endtask
	task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		tmo(n);
	endtask
	task pacc(input logic we, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		logic [31:0] s;
		logic [1:0]  r;
		int          n;
		axw(OFS_CMD, {we, 7'h00, a, d}, r);
		for (n = 0; n < 200; n++) begin
			axr(OFS_STATUS, s, r);
			if (s[ST_BUSY_BIT] === 1'b0)
				break;
		end
		tmo(n);
		q = s[15:0];
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cwe) begin
			check({23'h0, caddr}, {23'h0, xaddr});
			check({16'h0, cwd}, {16'h0, cm_word(val)});
			xaddr <= xaddr + 9'h001;
			ncm <= ncm + 1;
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [15:0] q;
		int          i, n, t0;
		void'($urandom(32'ha904));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(OFS_IRQ_STAT, d, r);
		check(d, 32'h0);
		check({16'h0, sen}, {16'h0, drive(1'b0, 1'b0)});
		axr(8'h20, d, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		axw(8'h24, 32'h0, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		for (i = 0; i < 4; i++) begin
			pin <= i[1];
			pacc(1'b1, ADDR_IMS, interface_mode_reg(5'h00, 1'b0, i[0], 1'b0), q);
			repeat (4) @(posedge aclk);
			check({16'h0, sen}, {16'h0, drive(i[1], i[0])});
		end
		axw(OFS_IRQ_CLR, 32'h3, r);
		axw(OFS_IRQ_EN, 32'h1, r);
		pacc(1'b0, ADDR_IMS, 16'h0000, q);
		check({16'h0, q}, {16'h0, interface_mode_reg(5'h00, 1'b0, 1'b1, 1'b0)});
		@(posedge aclk);
		check({31'h0, irq}, 32'h1);
		axw(OFS_IRQ_CLR, 32'h1, r);
		repeat (2) @(posedge aclk);
		check({31'h0, irq}, 32'h0);
		axw(OFS_IRQ_EN, 32'h0, r);
		pacc(1'b1, ADDR_CTRL, 16'h0000, q);
		axr(OFS_IRQ_STAT, d, r);
		check(d, 32'h1);
		check({31'h0, irq}, 32'h0);
		// Start without permit must fill nothing
		val = 5'($urandom);
		pacc(1'b1, ADDR_IMS, interface_mode_reg(val, 1'b1, 1'b1, 1'b0), q);
		repeat (FC) @(posedge aclk);
		check(ncm, 0);
		pacc(1'b1, ADDR_CTRL, 16'h0020, q);
		pacc(1'b1, ADDR_IMS, interface_mode_reg(val, 1'b1, 1'b1, 1'b0), q);
		t0 = cyc;
		repeat (FC / 2) @(posedge aclk);
		pacc(1'b1, ADDR_IMS, interface_mode_reg(val, 1'b1, 1'b1, 1'b0), q);
		for (n = 0; n < 3 * FC && ncm < CM_WORDS; n++)
			@(posedge aclk);
		check(ncm, CM_WORDS);
		check({31'h0, (cyc - t0) <= 2 * FC}, 32'h1);
		pacc(1'b0, ADDR_IMS, 16'h0000, q);
		check({16'h0, q}, {16'h0, interface_mode_reg(val, 1'b0, 1'b1, 1'b0)});
		// Second fill cut short by writing start low
		n = ncm;
		pacc(1'b1, ADDR_IMS, interface_mode_reg(val, 1'b1, 1'b1, 1'b0), q);
		repeat (FC / 2) @(posedge aclk);
		pacc(1'b1, ADDR_IMS, interface_mode_reg(val, 1'b0, 1'b1, 1'b0), q);
		repeat (FC) @(posedge aclk);
		check({31'h0, ncm > n}, 32'h1);
		check({31'h0, (ncm - n) < CM_WORDS}, 32'h1);
		pacc(1'b0, ADDR_IMS, 16'h0000, q);
		check({16'h0, q}, {16'h0, interface_mode_reg(val, 1'b0, 1'b1, 1'b0)});
		repeat (4 * FC) @(posedge aclk);
		pacc(1'b1, ADDR_IMS, interface_mode_reg(val, 1'b0, 1'b1, 1'b1), q);
		check({31'h0, evr}, 32'h1);
		done <= 1'b1;
		repeat (3) @(posedge aclk);
		check({31'h0, evr}, 32'h0);
		done <= 1'b0;
		// Restart too soon is refused by the host
		pacc(1'b1, ADDR_IMS, interface_mode_reg(val, 1'b0, 1'b1, 1'b0), q);
		pacc(1'b1, ADDR_IMS, interface_mode_reg(val, 1'b0, 1'b1, 1'b1), q);
		axr(OFS_IRQ_STAT, d, r);
		check({31'h0, d[IRQ_REFUSED]}, 32'h1);
		check({31'h0, evr}, 32'h0);
		repeat (3 * FC) @(posedge aclk);
		pacc(1'b1, ADDR_IMS, interface_mode_reg(val, 1'b0, 1'b1, 1'b1), q);
		check({31'h0, evr}, 32'h1);
		results;
	end
endmodule
`default_nettype wire
